/* File: include/sleep_wake_regs.svh */
// Constants for the sleep and wake-up event control block.
`ifndef SLEEP_WAKE_REGS_SVH
`define SLEEP_WAKE_REGS_SVH
`define PRIO_WIDTH        8
`define DEEP_WAKE_TIME_NS 200
`define DEEP_WAKE_CYCLES  ((`DEEP_WAKE_TIME_NS + 9) / 10)
`define LIGHT_WAKE_CYCLES 1
`endif

/* File: include/sleep_wake_pkg.sv */
// Types for the sleep and wake-up event control block.
package sleep_wake_pkg;
    typedef enum logic [1:0] {
        SLP_RUN,
        SLP_WAIT_EVENT,
        SLP_WAIT_INT,
        SLP_ON_RETURN
    } sleep_state_t;
endpackage : sleep_wake_pkg

/* File: src/event_latch.sv */
// Single-bit event latch; a set in the same cycle as a clear wins.
`timescale 1ns/1ns
module event_latch (
    // Clock and enable.
    input  wire logic clk_sys,
    input  wire logic clkEn,
    // Set and clear.
    input  wire logic setEvent,
    input  wire logic clearEvent,
    // State.
    output logic      eventSet
);
    logic eventQ;
    logic eventD;

    // No reset: the latch value after reset is undefined.
    assign eventD   = setEvent ? 1'b1 : (clearEvent ? 1'b0 : eventQ);
    assign eventSet = eventQ;

    always_ff @(posedge clk_sys) begin
        if (clkEn) begin
            eventQ <= eventD;
        end
    end
endmodule : event_latch

/* File: src/wake_qualifier.sv */
// Decides whether a pending asynchronous exception ends an interrupt wait.
`timescale 1ns/1ns
`include "sleep_wake_regs.svh"
module wake_qualifier #(
    parameter int PW = `PRIO_WIDTH
) (
    // Exception priorities (lower value is more urgent).
    input  wire logic          asyncValid,
    input  wire logic [PW-1:0] asyncPrio,
    input  wire logic [PW-1:0] activePrio,
    input  wire logic          anyActive,
    // Masks.
    input  wire logic          priority_mask_bit,
    input  wire logic          fault_mask_bit,
    input  wire logic [PW-1:0] base_priority_level,
    // Result.
    output logic               preempts,
    output logic               waitIntWake
);
    logic beatsActive;
    logic beatsBase;

    assign beatsActive = !anyActive || (asyncPrio < activePrio);
    assign beatsBase   = (base_priority_level == '0) || (asyncPrio < base_priority_level);
    assign preempts    = asyncValid && beatsActive;
    // With the priority mask set and the fault mask clear an exception above both levels still wakes.
    assign waitIntWake = asyncValid && beatsActive &&
                         ((priority_mask_bit && !fault_mask_bit) ? beatsBase : 1'b1);
endmodule : wake_qualifier

/* File: src/sleep_wake_event_control.sv */
// Sleep and wake-up control with event latch and sleeping indication.
//
// How it works
// - One single-bit event latch per processor.
// - Event latch has no reset value.
// - Wake-up events and exception return set latch.
// - Only wait-for-event clears the latch.
// - Latch not software readable or writable.
// - Latch set: clear it, complete immediately.
// - Latch clear: sleep until wake event.
// - Any processor's send event wakes all.
// - Pending-sets-event makes new pending wake.
// - Pre-empting exception or debug event wakes.
// - Send event goes out to all processors.
// - Early events are kept in latch.
// - Hints may complete without sleeping.
// - Interrupt wait ends on exception or debug.
// - Masked case needs priority above base level.
// - Interrupt wait ignores events before issue.
// - Interrupt wait ignores send and pending events.
// - Sleep-on-return suspends instead of returning.
// - Base priority need not end sleep-on-return.
// - Deep-sleep bit lengthens allowed wake time.
// - Suspension may end spuriously, e.g. debug.
`timescale 1ns/1ns
`include "sleep_wake_regs.svh"
module sleep_wake_event_control
    import sleep_wake_pkg::*;
#(
    parameter int PW = `PRIO_WIDTH
) (
    // Clock, enable and reset.
    input  wire logic          clk_sys,
    input  wire logic          clkEn,
    input  wire logic          srst,
    // Instruction pulses from the core.
    input  wire logic          wait_event_hint,
    input  wire logic          wait_interrupt_hint,
    input  wire logic          send_event_hint,
    input  wire logic          excReturn,
    input  wire logic          othersActive,
    // Hint disable: complete waits at once.
    input  wire logic          hintsAsNop,
    // Events from peers.
    input  wire logic          peerEventIn,
    // Exception and debug status.
    input  wire logic          pendRise,
    input  wire logic          asyncValid,
    input  wire logic [PW-1:0] asyncPrio,
    input  wire logic [PW-1:0] activePrio,
    input  wire logic          anyActive,
    input  wire logic          debugEvent,
    input  wire logic          debugEnable,
    input  wire logic          debugHalt,
    // Control bits of the system control word.
    input  wire logic          pending_sets_event,
    input  wire logic          sleep_on_return,
    input  wire logic          deepSleepEn,
    input  wire logic          priority_mask_bit,
    input  wire logic          fault_mask_bit,
    input  wire logic [PW-1:0] base_priority_level,
    // Results to the core.
    output logic               waitDone,
    output logic               returnSuppressed,
    output logic               tailChainNext,
    // Outputs to peers and power controller.
    output logic               sendEventOut,
    output logic               sleeping,
    output logic               sleepDeep,
    output logic               wakeReady
);
    sleep_state_t stateQ;
    sleep_state_t stateD;
    logic         eventSet;
    logic         preempts;
    logic         waitIntWake;
    logic         peerS1Q;
    logic         peerS2Q;
    logic         peerPrevQ;
    logic         peerPulse;
    logic         eventWake;
    logic         setEvent;
    logic         clearEvent;
    logic         debugWake;
    logic         enterWfe;
    logic         enterWfi;
    logic         enterSor;
    logic         wakeWfe;
    logic         leave;
    logic         waitDoneD;
    logic         suppressD;
    logic         tailQ;
    logic         tailD;
    logic         sendQ;
    logic         sleepingD;
    logic         deepQ;
    logic [15:0]  wakeCntQ;
    logic [15:0]  wakeCntD;
    logic         leaveEvt;
    logic         leaveInt;
    logic         leaveSor;
    logic         hintSeen;
    logic         deepD;
    logic [15:0]  wakeLoad;
    logic [15:0]  wakeNext;

    // True while the core executes normally; every decision that starts a wait looks at it.
    function automatic logic isRunning(input sleep_state_t st);
        return st == SLP_RUN;
    endfunction : isRunning

    assign debugWake = debugEvent && debugEnable;
    assign peerPulse = peerS2Q && !peerPrevQ;

    // Qualifying wake-up events for the event latch.
    assign eventWake = peerPulse || send_event_hint || (pending_sets_event && pendRise) ||
                       preempts || debugWake;
    assign setEvent  = eventWake || excReturn;
    // The latch is cleared only by a wait-for-event instruction.
    assign clearEvent = wait_event_hint && isRunning(stateQ);

    assign enterWfe = wait_event_hint && !eventSet && !hintsAsNop && isRunning(stateQ);
    assign enterWfi = wait_interrupt_hint && !hintsAsNop && !wait_event_hint && isRunning(stateQ);
    assign enterSor = excReturn && sleep_on_return && !othersActive && isRunning(stateQ);
    assign hintSeen = wait_event_hint || wait_interrupt_hint;

    // Events are qualified only once in the wait state, so earlier ones do not count here.
    assign wakeWfe  = eventWake;
    assign leaveEvt = (stateQ == SLP_WAIT_EVENT) && wakeWfe;
    assign leaveInt = (stateQ == SLP_WAIT_INT) && (waitIntWake || debugWake);
    assign leaveSor = (stateQ == SLP_ON_RETURN) && (preempts || debugWake);
    assign leave    = debugHalt || leaveEvt || leaveInt || leaveSor;

    always_comb begin
        stateD    = stateQ;
        waitDoneD = 1'b0;
        suppressD = 1'b0;
        tailD     = tailQ;
        case (stateQ)
            SLP_RUN: begin
                if (enterWfe) begin
                    stateD = SLP_WAIT_EVENT;
                end else if (enterWfi) begin
                    stateD = SLP_WAIT_INT;
                end else if (enterSor) begin
                    stateD    = SLP_ON_RETURN;
                    suppressD = 1'b1;
                end else if (hintSeen) begin
                    waitDoneD = 1'b1;
                end
                if (anyActive) begin
                    tailD = 1'b0;
                end
            end
            SLP_WAIT_EVENT, SLP_WAIT_INT: begin
                if (leave) begin
                    stateD    = SLP_RUN;
                    waitDoneD = 1'b1;
                end
            end
            SLP_ON_RETURN: begin
                if (leave) begin
                    stateD = SLP_RUN;
                    tailD  = 1'b1;
                end
            end
            default: begin
                stateD = SLP_RUN;
            end
        endcase
    end

    // Deep sleep stretches the time allowed before execution resumes.
    assign sleepingD = !isRunning(stateD);
    assign deepD     = sleepingD && deepSleepEn;
    assign wakeLoad  = deepSleepEn ? 16'(`DEEP_WAKE_CYCLES) : 16'(`LIGHT_WAKE_CYCLES);
    assign wakeNext  = (wakeCntQ != 16'h0000) ? wakeCntQ - 16'h0001 : 16'h0000;
    assign wakeCntD  = sleepingD ? wakeLoad : wakeNext;

    event_latch u_latch (
        .clk_sys    (clk_sys),
        .clkEn      (clkEn),
        .setEvent   (setEvent),
        .clearEvent (clearEvent),
        .eventSet   (eventSet)
    );

    wake_qualifier #(.PW(PW)) u_qual (
        .asyncValid          (asyncValid),
        .asyncPrio           (asyncPrio),
        .activePrio          (activePrio),
        .anyActive           (anyActive),
        .priority_mask_bit   (priority_mask_bit),
        .fault_mask_bit      (fault_mask_bit),
        .base_priority_level (base_priority_level),
        .preempts            (preempts),
        .waitIntWake         (waitIntWake)
    );

    // Two flops bring the peer line into this clock before the edge detector looks at it.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            peerS1Q <= 1'b0;
        end else if (clkEn) begin
            peerS1Q <= peerEventIn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            peerS2Q <= 1'b0;
        end else if (clkEn) begin
            peerS2Q <= peerS1Q;
        end
    end

    // Resets to the idle level of the line, so no false edge follows reset.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            peerPrevQ <= 1'b0;
        end else if (clkEn) begin
            peerPrevQ <= peerS2Q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stateQ <= SLP_RUN;
        end else if (clkEn) begin
            stateQ <= stateD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            waitDone <= 1'b0;
        end else if (clkEn) begin
            waitDone <= waitDoneD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            returnSuppressed <= 1'b0;
        end else if (clkEn) begin
            returnSuppressed <= suppressD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tailQ <= 1'b0;
        end else if (clkEn) begin
            tailQ <= tailD;
        end
    end

    // Our own send event goes out to the peers one cycle after the instruction.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sendQ <= 1'b0;
        end else if (clkEn) begin
            sendQ <= send_event_hint;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sleeping <= 1'b0;
        end else if (clkEn) begin
            sleeping <= sleepingD;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            deepQ <= 1'b0;
        end else if (clkEn) begin
            deepQ <= deepD;
        end
    end

    // Loaded while asleep and counted down once awake, so deep sleep delays readiness.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wakeCntQ <= 16'h0000;
        end else if (clkEn) begin
            wakeCntQ <= wakeCntD;
        end
    end

    assign tailChainNext = tailQ;
    assign sendEventOut  = sendQ;
    assign sleepDeep     = deepQ;
    assign wakeReady     = !sleeping && (wakeCntQ == 16'h0000);
endmodule : sleep_wake_event_control

/* File: tb/sleep_wake_assertions.sv */
// Assertions on the ports of the sleep and wake control.
`timescale 1ns/1ns
module sleep_wake_assertions (
    // Clock, reset and requests.
    input wire logic clk_sys,
    input wire logic clkEn,
    input wire logic srst,
    input wire logic wait_interrupt_hint,
    input wire logic send_event_hint,
    input wire logic excReturn,
    input wire logic othersActive,
    input wire logic hintsAsNop,
    input wire logic asyncValid,
    input wire logic debugHalt,
    input wire logic sleep_on_return,
    // Results.
    input wire logic waitDone,
    input wire logic returnSuppressed,
    input wire logic sendEventOut,
    input wire logic sleeping,
    input wire logic sleepDeep,
    input wire logic wakeReady
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_awake; clkEn && !sleeping && wakeReady; endsequence
    sequence s_held; returnSuppressed && sleeping; endsequence
    a_send_echo: assert property (send_event_hint && clkEn |=> sendEventOut) else $error("no echo");
    a_hint_nop: assert property (hintsAsNop && wait_interrupt_hint ##0 s_awake |=> waitDone)
        else $error("hint not done");
    a_int_sleeps: assert property (wait_interrupt_hint && !hintsAsNop && !asyncValid ##0 s_awake |=> sleeping)
        else $error("no sleep");
    a_ret_held: assert property (excReturn && sleep_on_return && !othersActive ##0 s_awake |=> s_held)
        else $error("return not held");
    a_ret_plain: assert property (excReturn && othersActive && clkEn |=> !returnSuppressed) else $error("held");
    a_deep_qual: assert property (sleepDeep |-> sleeping) else $error("deep while awake");
    a_halt_wake: assert property (sleeping && debugHalt && clkEn |-> ##[1:2] !sleeping) else $error("halt");
    a_ready_low: assert property (sleeping |-> !wakeReady) else $error("ready asleep");
endmodule : sleep_wake_assertions
bind sleep_wake_event_control sleep_wake_assertions sleep_wake_assertions_i (
    .clk_sys, .clkEn, .srst, .wait_interrupt_hint, .send_event_hint, .excReturn, .othersActive,
    .hintsAsNop, .asyncValid, .debugHalt, .sleep_on_return, .waitDone, .returnSuppressed,
    .sendEventOut, .sleeping, .sleepDeep, .wakeReady
);

/* File: tb/peer_event_model.sv */
// Peer processor whose send event drives the shared event line.
`timescale 1ns/1ns
module peer_event_model (
    // Clock and bench command.
    input wire logic clk_sys,
    input wire logic peerSend,
    input wire logic slowMode,
    // Shared event line, idle low.
    output logic     peerEvent
);
    logic [3:0] count_q = 4'h0;
    // The line is high for the last three counts, so a slow peer raises it later.
    always_ff @(posedge clk_sys) begin
        if (peerSend) begin
            count_q <= slowMode ? 4'h9 : 4'h3;
        end else if (count_q != 4'h0) begin
            count_q <= count_q - 4'h1;
        end
    end
    assign peerEvent = (count_q != 4'h0) && (count_q <= 4'h3);
endmodule : peer_event_model

/* File: tb/tb.sv */
// Self-checking bench for the sleep and wake control.
`timescale 1ns/1ns
`include "sleep_wake_regs.svh"
module tb;
    localparam logic [6:0] P_EVWAIT = 7'h01, P_INTWAIT = 7'h02, P_SEND = 7'h04, P_RET = 7'h08;
    localparam logic [6:0] P_PEND = 7'h10, P_DBG = 7'h20, P_HALT = 7'h40;
    logic clk_sys = 1'h0, clkEn = 1'h1, srst = 1'h1, hintsAsNop = 1'h0, othersActive = 1'h0;
    logic anyActive = 1'h0, asyncValid = 1'h0, debugEnable = 1'h0, pending_sets_event = 1'h0;
    logic sleep_on_return = 1'h0, deepSleepEn = 1'h0, priority_mask_bit = 1'h0, fault_mask_bit = 1'h0;
    logic peerSend = 1'h0, slowMode = 1'h1, peerEventIn;
    logic [6:0] pulses = 7'h00;
    logic [`PRIO_WIDTH-1:0] asyncPrio = 8'h00, activePrio = 8'h00, base_priority_level = 8'h00;
    logic waitDone, returnSuppressed, tailChainNext, sendEventOut, sleeping, sleepDeep, wakeReady;
    wire wait_event_hint = pulses[0], wait_interrupt_hint = pulses[1], send_event_hint = pulses[2];
    wire excReturn = pulses[3], pendRise = pulses[4], debugEvent = pulses[5], debugHalt = pulses[6];
    int errTotal = 0, samplesChecked = 0, cycles = 0;
    sleep_wake_event_control sleep_wake_event_control_i (
        .clk_sys, .clkEn, .srst, .wait_event_hint, .wait_interrupt_hint, .send_event_hint, .excReturn,
        .othersActive, .hintsAsNop, .peerEventIn, .pendRise, .asyncValid, .asyncPrio, .activePrio,
        .anyActive, .debugEvent, .debugEnable, .debugHalt, .pending_sets_event, .sleep_on_return,
        .deepSleepEn, .priority_mask_bit, .fault_mask_bit, .base_priority_level, .waitDone,
        .returnSuppressed, .tailChainNext, .sendEventOut, .sleeping, .sleepDeep, .wakeReady
    );
    peer_event_model peer_event_model_i (.clk_sys, .peerSend, .slowMode, .peerEvent(peerEventIn));
    task automatic conclude();
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic ok, input string msg);
        samplesChecked++;
        if (ok !== 1'h1) begin
            errTotal++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick
    // An idle cycle first keeps back-to-back pulses from touching the same time step.
    task automatic pulse(input logic [6:0] p);
        tick(1);
        pulses = p;
        tick(1);
        pulses = 7'h00;
    endtask : pulse
    task automatic waitFor(input int n, input logic wantDone, input string msg);
        for (int i = 0; i < n && (wantDone ? waitDone : !sleeping) !== 1'h1; i++) begin
            tick(1);
        end
        check((wantDone ? waitDone : !sleeping) === 1'h1, msg);
    endtask : waitFor
    task automatic scEvents();
        pulse(P_SEND);
        check(sendEventOut === 1'h1, "send not echoed");
        pulse(P_EVWAIT);
        check(waitDone === 1'h1 && sleeping === 1'h0, "set latch slept");
        pulse(P_EVWAIT);
        check(sleeping === 1'h1, "clear latch no sleep");
        peerSend = 1'h1;
        tick(1);
        peerSend = 1'h0;
        waitFor(16, 1'h1, "peer event no wake");
        pulse(P_EVWAIT);
        check(waitDone === 1'h1 && sleeping === 1'h0, "wake not latched");
    endtask : scEvents
    task automatic scPending();
        pending_sets_event = 1'h1;
        pulse(P_PEND);
        pulse(P_EVWAIT);
        check(waitDone === 1'h1 && sleeping === 1'h0, "pending lost");
        pending_sets_event = 1'h0;
        pulse(P_PEND);
        pulse(P_EVWAIT);
        check(sleeping === 1'h1, "pending woke when off");
        pulse(P_HALT);
        waitFor(3, 1'h0, "halt no wake");
    endtask : scPending
    task automatic scWait();
        hintsAsNop = 1'h1;
        pulse(P_INTWAIT);
        check(waitDone === 1'h1 && sleeping === 1'h0, "no-op hint slept");
        hintsAsNop = 1'h0;
        anyActive = 1'h1;
        activePrio = 8'h05;
        priority_mask_bit = 1'h1;
        base_priority_level = 8'h04;
        debugEnable = 1'h1;
        pulse(P_DBG);
        pulse(P_INTWAIT);
        check(sleeping === 1'h1, "early event ended wait");
        asyncPrio = 8'h04;
        asyncValid = 1'h1;
        tick(4);
        check(sleeping === 1'h1, "base level woke");
        asyncPrio = 8'h03;
        waitFor(4, 1'h1, "above base no wake");
        asyncValid = 1'h0;
        pulse(P_INTWAIT);
        pulse(P_DBG);
        waitFor(4, 1'h1, "debug no wake");
    endtask : scWait
    task automatic scReturn();
        anyActive = 1'h0;
        othersActive = 1'h1;
        sleep_on_return = 1'h1;
        deepSleepEn = 1'h1;
        pulse(P_RET);
        check(returnSuppressed === 1'h0 && sleeping === 1'h0, "held with others");
        othersActive = 1'h0;
        pulse(P_RET);
        check(returnSuppressed === 1'h1 && sleepDeep === 1'h1, "return not held");
        asyncPrio = 8'h01;
        asyncValid = 1'h1;
        waitFor(4, 1'h0, "preempt no wake");
        asyncValid = 1'h0;
        check(tailChainNext === 1'h1, "not chained");
        tick(`LIGHT_WAKE_CYCLES + 1);
        check(wakeReady === 1'h0, "deep wake quick");
        tick(`DEEP_WAKE_CYCLES + 2);
        check(wakeReady === 1'h1, "deep wake slow");
        sleep_on_return = 1'h0;
        pulse(P_EVWAIT);
        check(waitDone === 1'h1, "return no latch");
    endtask : scReturn
    task automatic scFreeze();
        pulse(P_EVWAIT);
        check(sleeping === 1'h1, "cleared latch no sleep");
        clkEn = 1'h0;
        pulse(P_SEND);
        tick(2);
        check(sleeping === 1'h1 && waitDone === 1'h0 && sendEventOut === 1'h0, "moved while disabled");
        clkEn = 1'h1;
        asyncPrio = 8'h01;
        asyncValid = 1'h1;
        waitFor(4, 1'h1, "preempt no event wake");
        asyncValid = 1'h0;
    endtask : scFreeze
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errTotal++;
            conclude();
        end
    end
    initial begin
        tick(6);
        srst = 1'h0;
        check(wakeReady === 1'h1 && sleeping === 1'h0, "reset state");
        scEvents();
        scPending();
        scWait();
        scReturn();
        scFreeze();
        conclude();
    end
endmodule : tb
